// ---- hdl/wcd_consts.svh ----
// constants for the watchpoint coupling and debug comms block
// assumes inclusion by the package and by the design file
`ifndef WCD_CONSTS_SVH
`define WCD_CONSTS_SVH
`define WCD_COPROC_NUM 4'he
`define WCD_OPC_COMMS 3'h0
`define WCD_CRN_CTRL 4'h0
`define WCD_CRN_DATA 4'h1
`define WCD_CRM_COMMS 4'h0
`define WCD_VER_MSB 31
`define WCD_VER_LSB 28
`define WCD_BIT_W 1
`define WCD_BIT_R 0
`define WCD_FULL_AC 37'h1f_ffff_ffff
`define WCD_FULL_DC 35'h7_ffff_ffff
`endif

// ---- hdl/wcd_pkg.sv ----
// types for the watchpoint coupling and debug comms block
// assumes wcd_consts.svh is available
`include "wcd_consts.svh"
package wcd_pkg;
  // coprocessor register transfer request from the core
  typedef struct packed {
    logic valid;
    logic rd;
    logic [3:0] cp_num;
    logic [2:0] opc;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [31:0] wdata;
  } wcd_coproc_register_transfer_type;
  // one watchpoint unit's compare inputs
  typedef struct packed {
    logic [31:0] addr_v;
    logic [31:0] addr_m;
    logic [31:0] data_v;
    logic [31:0] data_m;
    logic [8:0] ctrl_v;
    logic [7:0] ctrl_m;
    logic enable;
  } wcd_wp_type;
  typedef enum logic [1:0] {
    WCD_SC_IDLE = 2'h0,
    WCD_SC_BUSY = 2'h1
  } wcd_scan_st_type;
endpackage : wcd_pkg

// ---- hdl/wcd_top.sv ----
// watchpoint coupling and debug communications channel
// assumes core on clk and scan chain logic on tck, both resets synchronous
// Notes on behaviour
// - chained unit 0 triggers only after unit 1 matched earlier
// - range coupling combines both units' match outputs into a range check
// - link match evaluated on full address/control match, gives data/control match
// - unit 1 link match output drives unit 0 chain input
// - link match held in latch loaded on address match with data result
// - unit 1 span match output drives unit 0 range input
// - mask-based ranges are power-of-two sizes only
// - disabled unit 1 still drives span match but never triggers itself
// - comms channel appears as coprocessor 14
// - 32-bit host-to-core, 32-bit core-to-host, 32-bit handshake register
// - handshake register read only, top four bits fixed version
// - bit 1 flags core-to-host register occupied
// - bit 0 flags unread host data in host-to-core register
// - core write to core-to-host register sets occupied flag
// - host sees flags synchronised to scan clock
// - scan read of core-to-host register clears occupied flag
// - scan write of host-to-core register sets unread flag
// - core sees flags synchronised to core clock
// - core load of host-to-core register clears unread flag
// - opcode 0 decode: C0,C0 control read; C1,C0 write/read data
`timescale 1ns/10ps
`default_nettype none
`include "wcd_consts.svh"
module wcd_top
  import wcd_pkg::*;
#(
  parameter logic [3:0] VERSION_ID = 4'h5 // arbitrary value
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tck,
  input wire logic tck_rstn,
  input wire wcd_wp_type wp1,
  input wire wcd_wp_type wp0,
  input wire logic [31:0] addr_bus,
  input wire logic [31:0] data_bus,
  input wire logic [9:0] ctrl_bus,
  input wire logic chain_sel,
  input wire logic range_sel,
  output logic link_match_out,
  output logic span_match_out,
  output logic breakpt,
  input wire wcd_coproc_register_transfer_type coproc_register_transfer,
  output logic coproc_register_transfer_hit,
  output logic [31:0] coproc_register_transfer_rdata,
  input wire logic scan_wr,
  input wire logic [31:0] scan_wdata,
  input wire logic scan_rd,
  output logic [31:0] scan_rdata,
  output logic [1:0] scan_flags
);

  // ---------------------------------------------------------------
  // watchpoint compare and coupling
  // ---------------------------------------------------------------
  // masking drops whole low bits, so ranges are power-of-two sized
  // per-unit masked compares, index 1 and 0
  wcd_wp_type [1:0] wp_arr;
  assign wp_arr = {wp1, wp0};
  wire [1:0] am_v;
  wire [1:0] dm_v;
  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_unit
    wire [36:0] a_val = {wp_arr[gi].addr_v, wp_arr[gi].ctrl_v[4:0]};
    wire [36:0] a_msk = {wp_arr[gi].addr_m, wp_arr[gi].ctrl_m[4:0]};
    wire [34:0] d_val = {wp_arr[gi].data_v, wp_arr[gi].ctrl_v[6:4]};
    wire [34:0] d_msk = {wp_arr[gi].data_m, wp_arr[gi].ctrl_m[7:5]};
    wire [36:0] a_cmp = (a_val ~^ {addr_bus, ctrl_bus[4:0]}) | a_msk;
    wire [34:0] d_cmp = (d_val ~^ {data_bus, ctrl_bus[7:5]}) | d_msk;
    assign am_v[gi] = (a_cmp == `WCD_FULL_AC);
    assign dm_v[gi] = (d_cmp == `WCD_FULL_DC);
  end
  wire am1 = am_v[1];
  wire dm1 = dm_v[1];
  wire am0 = am_v[0];
  wire dm0 = dm_v[0];
  logic link_r;
  logic link_nxt;
  assign link_nxt = am1 ? dm1 : link_r;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      link_r <= 1'b0;
    end else begin
      link_r <= link_nxt;
    end
  end
  wire span1 = am1 & dm1;
  wire chain_ok = ~chain_sel | link_r;
  wire range_ok = ~range_sel | (span1 == wp0.ctrl_v[8]);
  wire trig0 = wp0.enable & am0 & dm0 & chain_ok & range_ok;
  wire trig1 = wp1.enable & span1;
  logic bp_r;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bp_r <= 1'b0;
    end else begin
      bp_r <= trig0 | trig1;
    end
  end
  assign link_match_out = link_r;
  assign span_match_out = span1;
  assign breakpt = bp_r;

  // ---------------------------------------------------------------
  // coprocessor decode, core domain
  // ---------------------------------------------------------------
  wire cp_ok = coproc_register_transfer.valid & (coproc_register_transfer.cp_num == `WCD_COPROC_NUM)
               & (coproc_register_transfer.opc == `WCD_OPC_COMMS) & (coproc_register_transfer.crm == `WCD_CRM_COMMS);
  wire rd_ctrl = cp_ok & coproc_register_transfer.rd & (coproc_register_transfer.crn == `WCD_CRN_CTRL);
  wire wr_data = cp_ok & ~coproc_register_transfer.rd & (coproc_register_transfer.crn == `WCD_CRN_DATA);
  wire rd_data = cp_ok & coproc_register_transfer.rd & (coproc_register_transfer.crn == `WCD_CRN_DATA);
  assign coproc_register_transfer_hit = rd_ctrl | wr_data | rd_data;

  logic [31:0] c2h_r;
  logic [31:0] h2c_r;
  logic w_tgl_r; // core write toggles
  logic r_ack_tgl_r; // core load toggles
  logic [2:0] wack_s_r; // scan read toggle into core
  logic [2:0] rset_s_r; // scan write toggle into core
  logic wack_q_r;
  logic rset_q_r;
  logic wack_tgl_r;
  logic rset_tgl_r;
  logic [31:0] coproc_register_transfer_rdata_r;

  // core view of flags from toggle differences
  wire core_w = w_tgl_r ^ wack_q_r;
  wire core_r = r_ack_tgl_r ^ rset_q_r;
  wire [31:0] ctrl_word = {VERSION_ID, 26'h0, core_w, core_r};
  wire w_go = wr_data & ~core_w;
  wire r_go = rd_data & core_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      w_tgl_r <= 1'b0;
      r_ack_tgl_r <= 1'b0;
      wack_s_r <= 3'h0;
      rset_s_r <= 3'h0;
      wack_q_r <= 1'b0;
      rset_q_r <= 1'b0;
      c2h_r <= 32'h0;
      coproc_register_transfer_rdata_r <= 32'h0;
    end else begin
      wack_s_r <= {wack_s_r[1:0], wack_tgl_r};
      rset_s_r <= {rset_s_r[1:0], rset_tgl_r};
      if (wack_s_r[2] == wack_s_r[1]) begin
        wack_q_r <= wack_s_r[2];
      end
      if (rset_s_r[2] == rset_s_r[1]) begin
        rset_q_r <= rset_s_r[2];
      end
      if (w_go) begin
        c2h_r <= coproc_register_transfer.wdata;
        w_tgl_r <= ~w_tgl_r;
      end
      if (r_go) begin
        r_ack_tgl_r <= ~r_ack_tgl_r;
      end
      if (rd_ctrl) begin
        coproc_register_transfer_rdata_r <= ctrl_word;
      end else if (rd_data) begin
        coproc_register_transfer_rdata_r <= h2c_r;
      end
    end
  end
  assign coproc_register_transfer_rdata = coproc_register_transfer_rdata_r;

  // ---------------------------------------------------------------
  // scan side, tck domain
  // ---------------------------------------------------------------
  logic [2:0] wset_t_r;
  logic [2:0] rack_t_r;
  logic wset_q_r;
  logic rack_q_r;
  logic [31:0] scan_rdata_r;
  wire scan_w = wset_q_r ^ wack_tgl_r;
  wire scan_r = rset_tgl_r ^ rack_q_r;
  always_ff @(posedge tck) begin
    if (!tck_rstn) begin
      wack_tgl_r <= 1'b0;
      rset_tgl_r <= 1'b0;
      wset_t_r <= 3'h0;
      rack_t_r <= 3'h0;
      wset_q_r <= 1'b0;
      rack_q_r <= 1'b0;
      h2c_r <= 32'h0;
      scan_rdata_r <= 32'h0;
    end else begin
      wset_t_r <= {wset_t_r[1:0], w_tgl_r};
      rack_t_r <= {rack_t_r[1:0], r_ack_tgl_r};
      if (wset_t_r[2] == wset_t_r[1]) begin
        wset_q_r <= wset_t_r[2];
      end
      if (rack_t_r[2] == rack_t_r[1]) begin
        rack_q_r <= rack_t_r[2];
      end
      if (scan_rd & scan_w) begin
        scan_rdata_r <= c2h_r;
        wack_tgl_r <= ~wack_tgl_r;
      end
      if (scan_wr & ~scan_r) begin
        h2c_r <= scan_wdata;
        rset_tgl_r <= ~rset_tgl_r;
      end
    end
  end
  assign scan_rdata = scan_rdata_r;
  assign scan_flags = {scan_w, scan_r};

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_link_load;
    @(posedge clk) disable iff (!rstn) am1 |=> (link_r == $past(dm1));
  endproperty
  a_link_load: assert property (p_link_load) else $error("link latch load wrong");
  property p_link_hold;
    @(posedge clk) disable iff (!rstn) !am1 |=> $stable(link_r);
  endproperty
  a_link_hold: assert property (p_link_hold) else $error("link latch moved");
  property p_chain;
    @(posedge clk) disable iff (!rstn) (chain_sel & !link_r & !trig1) |=> !bp_r;
  endproperty
  a_chain: assert property (p_chain) else $error("chain trigger early");
  property p_disabled;
    @(posedge clk) disable iff (!rstn) (!wp1.enable & !trig0) |=> !bp_r;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled unit fired");
  property p_wset;
    @(posedge clk) disable iff (!rstn) w_go |=> core_w;
  endproperty
  a_wset: assert property (p_wset) else $error("occupied not set");
  property p_rclr;
    @(posedge clk) disable iff (!rstn) r_go |=> !core_r;
  endproperty
  a_rclr: assert property (p_rclr) else $error("unread not cleared");
  property p_ver;
    @(posedge clk) disable iff (!rstn) rd_ctrl |=> coproc_register_transfer_rdata[31:28] == VERSION_ID;
  endproperty
  a_ver: assert property (p_ver) else $error("version field wrong");
  property p_wclr;
    @(posedge tck) disable iff (!tck_rstn) (scan_rd & scan_w) |=> !scan_w;
  endproperty
  a_wclr: assert property (p_wclr) else $error("scan read kept occupied");
  property p_rset;
    @(posedge tck) disable iff (!tck_rstn) (scan_wr & !scan_r) |=> scan_r;
  endproperty
  a_rset: assert property (p_rset) else $error("scan write left unread clear");
  property p_span_dis;
    @(posedge clk) disable iff (!rstn) (!wp1.enable & am1 & dm1) |-> span_match_out;
  endproperty
  a_span_dis: assert property (p_span_dis) else $error("disabled unit lost span");
  property p_wp1_fire;
    @(posedge clk) disable iff (!rstn) (wp1.enable & am1 & dm1) |=> bp_r;
  endproperty
  a_wp1_fire: assert property (p_wp1_fire) else $error("unit 1 did not fire");
  property p_range_stop;
    @(posedge clk) disable iff (!rstn)
      (range_sel & (span1 != wp0.ctrl_v[8]) & !trig1) |=> !bp_r;
  endproperty
  a_range_stop: assert property (p_range_stop) else $error("range mismatch fired");
  property p_range_pass;
    @(posedge clk) disable iff (!rstn)
      (range_sel & !chain_sel & wp0.enable & am0 & dm0 & (span1 == wp0.ctrl_v[8])) |=> bp_r;
  endproperty
  a_range_pass: assert property (p_range_pass) else $error("range match missed");
  property p_chain_fire;
    @(posedge clk) disable iff (!rstn)
      (chain_sel & !range_sel & link_r & wp0.enable & am0 & dm0) |=> bp_r;
  endproperty
  a_chain_fire: assert property (p_chain_fire) else $error("chained unit missed");
  property p_plain_fire;
    @(posedge clk) disable iff (!rstn)
      (!chain_sel & !range_sel & wp0.enable & am0 & dm0) |=> bp_r;
  endproperty
  a_plain_fire: assert property (p_plain_fire) else $error("unit 0 missed");

  // ---------------------------------------------------------------
  // assertions, core handshake
  // ---------------------------------------------------------------
  property p_w_refuse;
    @(posedge clk) disable iff (!rstn) (wr_data & core_w) |=> $stable(c2h_r);
  endproperty
  a_w_refuse: assert property (p_w_refuse) else $error("write while occupied");
  property p_w_load;
    @(posedge clk) disable iff (!rstn) w_go |=> (c2h_r == $past(coproc_register_transfer.wdata));
  endproperty
  a_w_load: assert property (p_w_load) else $error("core write data lost");
  property p_r_refuse;
    @(posedge clk) disable iff (!rstn) (rd_data & !core_r) |=> $stable(r_ack_tgl_r);
  endproperty
  a_r_refuse: assert property (p_r_refuse) else $error("empty load acknowledged");
  property p_cp_num;
    @(posedge clk) disable iff (!rstn)
      (coproc_register_transfer.valid & (coproc_register_transfer.cp_num != `WCD_COPROC_NUM)) |-> !coproc_register_transfer_hit;
  endproperty
  a_cp_num: assert property (p_cp_num) else $error("wrong coprocessor hit");
  property p_opc;
    @(posedge clk) disable iff (!rstn) (coproc_register_transfer.valid & (coproc_register_transfer.opc != `WCD_OPC_COMMS)) |-> !coproc_register_transfer_hit;
  endproperty
  a_opc: assert property (p_opc) else $error("wrong opcode hit");
  property p_ctrl_zero;
    @(posedge clk) disable iff (!rstn) rd_ctrl |=> (coproc_register_transfer_rdata[27:2] == 26'h0);
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("control spare bits set");
  property p_ctrl_flags;
    @(posedge clk) disable iff (!rstn) rd_ctrl |=> (coproc_register_transfer_rdata[1:0] == $past({core_w, core_r}));
  endproperty
  a_ctrl_flags: assert property (p_ctrl_flags) else $error("control flags wrong");
  property p_h2c_read;
    @(posedge clk) disable iff (!rstn) (rd_data & core_r) |=> (coproc_register_transfer_rdata == $past(h2c_r));
  endproperty
  a_h2c_read: assert property (p_h2c_read) else $error("host data read wrong");
  property p_core_rst;
    @(posedge clk) $rose(rstn) |-> (!core_w & !core_r);
  endproperty
  a_core_rst: assert property (p_core_rst) else $error("core flags not clear");

  // ---------------------------------------------------------------
  // assertions, scan domain
  // ---------------------------------------------------------------
  property p_scan_rd;
    @(posedge tck) disable iff (!tck_rstn)
      (scan_rd & scan_w) |=> (scan_rdata == $past(c2h_r));
  endproperty
  a_scan_rd: assert property (p_scan_rd) else $error("scan read data wrong");
  property p_scan_refuse;
    @(posedge tck) disable iff (!tck_rstn) (scan_wr & scan_r) |=> $stable(h2c_r);
  endproperty
  a_scan_refuse: assert property (p_scan_refuse) else $error("scan overwrite");
  property p_scan_rst;
    @(posedge tck) $rose(tck_rstn) |-> (scan_flags == 2'h0);
  endproperty
  a_scan_rst: assert property (p_scan_rst) else $error("scan flags not clear");

  // ---------------------------------------------------------------
  // cover points
  // ---------------------------------------------------------------
  c_chain: cover property (@(posedge clk) disable iff (!rstn) chain_sel & link_r & trig0);
  c_span_dis: cover property (@(posedge clk) disable iff (!rstn) range_sel & !wp1.enable & span1);
  c_range: cover property (@(posedge clk) disable iff (!rstn) range_sel & trig0);
  c_core_wr: cover property (@(posedge clk) disable iff (!rstn) w_go);
  c_scan_wr: cover property (@(posedge tck) disable iff (!tck_rstn) scan_wr & !scan_r);

endmodule : wcd_top
`default_nettype wire

// ---- test/tb.sv ----
// testbench for the watchpoint coupling and comms block
// assumes the host model on the scan side
`timescale 1ns/10ps
`default_nettype none
module tb
  import wcd_pkg::*;
;
  localparam logic [3:0] VER = 4'ha; // arbitrary value
  logic clk, tck, rstn, tck_rstn, chain_sel, range_sel, link_match_out, span_match_out;
  logic breakpt, coproc_register_transfer_hit, scan_wr, scan_rd, tx_req;
  logic [31:0] addr_bus, data_bus, coproc_register_transfer_rdata, scan_wdata, scan_rdata, tx_data, rx_data;
  logic [31:0] rd_v, d;
  logic [15:0] lf;
  logic [1:0] scan_flags;
  wcd_wp_type wp1, wp0;
  wcd_coproc_register_transfer_type coproc_register_transfer;
  int err_count, n_checks, k;
  logic [31:0] ra [6] = '{32'h10, 32'h80, 32'h1f, 32'h20, 32'hff, 32'h100};
  logic [2:0] re [6] = '{3'h6, 3'h3, 3'h6, 3'h3, 3'h3, 3'h2};
  wcd_top #(.VERSION_ID(VER)) dut (.clk(clk), .rstn(rstn), .tck(tck), .tck_rstn(tck_rstn),
    .wp1(wp1), .wp0(wp0), .addr_bus(addr_bus), .data_bus(data_bus), .ctrl_bus(10'h0),
    .chain_sel(chain_sel), .range_sel(range_sel), .link_match_out(link_match_out),
    .span_match_out(span_match_out), .breakpt(breakpt), .coproc_register_transfer(coproc_register_transfer), .coproc_register_transfer_hit(coproc_register_transfer_hit),
    .coproc_register_transfer_rdata(coproc_register_transfer_rdata), .scan_wr(scan_wr), .scan_wdata(scan_wdata), .scan_rd(scan_rd),
    .scan_rdata(scan_rdata), .scan_flags(scan_flags));
  wcd_host_model host (.tck(tck), .tck_rstn(tck_rstn), .scan_flags(scan_flags),
    .scan_rdata(scan_rdata), .tx_req(tx_req), .tx_data(tx_data), .scan_wr(scan_wr),
    .scan_wdata(scan_wdata), .scan_rd(scan_rd), .rx_data(rx_data));
  // ----------------
  // helpers
  // ----------------
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx
  task automatic rnd(output logic [31:0] v);
    lf = nx(lf);
    v[31:16] = lf;
    lf = nx(lf);
    v[15:0] = lf;
  endtask : rnd
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cp(input logic rd, input logic [3:0] n, input logic [2:0] o,
                    input logic [3:0] c, input logic [31:0] w, input logic hit);
    @(posedge clk);
    coproc_register_transfer <= '{1'b1, rd, n, o, c, 4'h0, w};
    #1 chk("hit", coproc_register_transfer_hit, hit);
    @(posedge clk);
    coproc_register_transfer.valid <= 1'b0;
    @(posedge clk);
    #1 rd_v = coproc_register_transfer_rdata;
  endtask : cp
  task automatic poll(input int b, input logic v);
    for (int i = 0; i < 300; i++) begin
      cp(1'b1, 4'he, 3'h0, 4'h0, 32'h0, 1'b1);
      if (rd_v[b] === v) break;
    end
    chk("flag", rd_v[b], v);
  endtask : poll
  task automatic ws(input logic [31:0] a, input logic [31:0] dd, input logic [2:0] e);
    @(posedge clk);
    addr_bus <= a;
    data_bus <= dd;
    repeat (2) @(posedge clk);
    #1 chk("wp", {span_match_out, link_match_out, breakpt}, e);
  endtask : ws
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  initial begin
    {clk, tck, rstn, tck_rstn, chain_sel, range_sel, tx_req} = '0;
    {addr_bus, data_bus, tx_data, coproc_register_transfer, wp1, wp0} = '0;
    {err_count, n_checks} = '0;
    lf = 16'd16492;
  end
  initial forever #2.5 clk = ~clk;
  initial begin
    #1.3;
    forever #3 tck = ~tck;
  end
  initial begin
    #100000;
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    tck_rstn <= 1'b1;
    repeat (10) @(posedge clk);
    cp(1'b1, 4'he, 3'h0, 4'h0, 32'h0, 1'b1);
    chk("ctrl", rd_v, {VER, 28'h0});
    chk("sflags", scan_flags, 32'h0);
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      if (k < 2) d = k ? 32'h0 : 32'hffffffff;
      else rnd(d);
      cp(1'b0, 4'he, 3'h0, 4'h1, d, 1'b1);
      cp(1'b0, 4'he, 3'h0, 4'h1, ~d, 1'b1);
      poll(1, 1'b0);
      chk("c2h", rx_data, d);
    end
    $display("test core to host done");
    for (k = 0; k < 3; k++) begin
      rnd(d);
      tx_data <= d;
      tx_req <= ~tx_req;
      poll(0, 1'b1);
      cp(1'b1, 4'he, 3'h0, 4'h1, 32'h0, 1'b1);
      chk("h2c", rd_v, d);
      poll(0, 1'b0);
    end
    $display("test host to core done");
    cp(1'b1, 4'h7, 3'h0, 4'h0, 32'h0, 1'b0);
    cp(1'b1, 4'he, 3'h1, 4'h0, 32'h0, 1'b0);
    cp(1'b1, 4'he, 3'h0, 4'h2, 32'h0, 1'b0);
    $display("test decode done");
    wp1 <= '{32'h0, 32'h1f, 32'h0, '1, 9'h0, 8'hff, 1'b0};
    wp0 <= '{32'h0, 32'hff, 32'h0, '1, 9'h0, 8'hff, 1'b1};
    range_sel <= 1'b1;
    for (k = 0; k < 6; k++) ws(ra[k], 32'h0, re[k]);
    $display("test range done");
    rnd(d);
    wp1 <= '{32'h4000, 32'h0, d, 32'h0, 9'h0, 8'hff, 1'b0};
    wp0 <= '{32'h8000, 32'h0, 32'h0, '1, 9'h0, 8'hff, 1'b1};
    range_sel <= 1'b0;
    chain_sel <= 1'b1;
    ws(32'h4000, ~d, 3'h0);
    ws(32'h8000, d, 3'h0);
    ws(32'h4000, d, 3'h6);
    ws(32'h8000, d, 3'h3);
    ws(32'h4000, ~d, 3'h0);
    ws(32'h8000, d, 3'h0);
    $display("test chain done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire

// ---- test/wcd_host_model.sv ----
// host debugger model on the scan side
// assumes flags and scan pulses timed on tck
`timescale 1ns/10ps
`default_nettype none
module wcd_host_model
  import wcd_pkg::*;
(
  input wire logic tck,
  input wire logic tck_rstn,
  input wire logic [1:0] scan_flags,
  input wire logic [31:0] scan_rdata,
  input wire logic tx_req,
  input wire logic [31:0] tx_data,
  output logic scan_wr,
  output logic [31:0] scan_wdata,
  output logic scan_rd,
  output logic [31:0] rx_data
);
  logic tx_ack_r;
  logic cap_r;
  logic [1:0] hold_r;
  always_ff @(posedge tck) begin
    scan_wr <= 1'b0;
    scan_rd <= 1'b0;
    cap_r <= scan_rd;
    if (scan_wr) scan_wdata <= ~scan_wdata;
    if (cap_r) rx_data <= scan_rdata;
    if (!tck_rstn) begin
      tx_ack_r <= 1'b0;
      hold_r <= 2'h3;
      scan_wdata <= 32'h0;
    end else if (hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
    end else if (scan_flags[1]) begin
      scan_rd <= 1'b1;
      hold_r <= 2'h3;
    end else if (tx_req != tx_ack_r && !scan_flags[0]) begin
      scan_wr <= 1'b1;
      scan_wdata <= tx_data;
      tx_ack_r <= tx_req;
      hold_r <= 2'h3;
    end
  end
endmodule : wcd_host_model
`default_nettype wire
